// ===== inc/ues_pkg.sv
// Package for the endpoint status and command block.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package ues_pkg;

  // ----------------------------------------
  // Endpoint map
  // ----------------------------------------
  localparam int unsigned EP_N      = 16;
  localparam logic [3:0]  EP_CTL_OUT = 4'h0;
  localparam logic [3:0]  EP_CTL_IN  = 4'h1;

  // ----------------------------------------
  // Command operation nibbles
  // ----------------------------------------
  localparam logic [3:0] OP_STALL    = 4'h4;
  localparam logic [3:0] OP_RDSTAT   = 4'h5;
  localparam logic [3:0] OP_VALIDATE = 4'h6;
  localparam logic [3:0] OP_CLEAR    = 4'h7;
  localparam logic [3:0] OP_UNSTALL  = 4'h8;
  localparam logic [3:0] OP_CHECK    = 4'hd;
  localparam logic [7:0] CMD_ACK_SETUP = 8'hf4;

  // ----------------------------------------
  // Status byte layout
  // ----------------------------------------
  localparam int unsigned BIT_HALT  = 7;
  localparam int unsigned BIT_FULL1 = 6;
  localparam int unsigned BIT_FULL0 = 5;
  localparam int unsigned BIT_TOG   = 4;
  localparam int unsigned BIT_CLOB  = 3;
  localparam int unsigned BIT_SETUP = 2;
  localparam int unsigned BIT_CPU   = 1;
  localparam logic [7:0]  COPY_RST  = 8'h00;

  // Per-endpoint state
  typedef struct packed {
    logic       halted;
    logic [1:0] full;
    logic       toggle;
    logic       clobber;
    logic       setup;
    logic       cpusel;
  } ues_ep_s;

  localparam ues_ep_s EP_RST = '0;

  // Command from the microcontroller port
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } ues_cmd_s;

  // Event from the serial engine
  typedef struct packed {
    logic       setup_tok;
    logic       setup_done;
    logic       out_done;
    logic       in_done;
    logic [3:0] ep;
  } ues_usb_s;

endpackage

// ===== hdl/ues_core.sv
// Endpoint status keeping and command decode for a full-speed USB function.
// Assumes commands and engine events are synchronous to clk_sys_i.
module ues_core
  import ues_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // Microcontroller commands
  input  wire ues_cmd_s            cmd_i,
  output logic [7:0]               rd_data_o,
  output logic                     rd_valid_o,
  output logic                     irq_clr_o,
  output logic [3:0]               irq_clr_ep_o,
  output logic                     ptr_rst_o,
  output logic [3:0]               ptr_rst_ep_o,
  // Endpoint configuration
  input  wire logic [EP_N-1:0]     ep_is_in_i,
  input  wire logic [EP_N-1:0]     ep_dbl_i,
  // Serial engine side
  input  wire ues_usb_s            usb_i,
  input  wire logic                setup_busy_i,
  output logic                     nak_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ues_ep_s    ep_reg   [EP_N];
  ues_ep_s    ep_next  [EP_N];
  logic [7:0] copy_reg, copy_next;
  logic       rdv_reg, rdv_next;
  logic       irq_reg, irq_next;
  logic [3:0] irqe_reg, irqe_next;
  logic       prst_reg, prst_next;
  logic [3:0] prste_reg, prste_next;
  logic       lock_reg, lock_next;
  logic       unst_reg, unst_next;
  logic [3:0] unste_reg, unste_next;

  logic [3:0] op, idx;
  logic       is_in   [EP_N];
  logic       usb_side[EP_N];
  logic       ctl_blk_w;

  assign op  = cmd_i.code[7:4];
  assign idx = cmd_i.code[3:0];
  assign ctl_blk_w = lock_reg && (idx == EP_CTL_OUT || idx == EP_CTL_IN);

  // Control endpoints have fixed direction
  always_comb begin
    for (int i = 0; i < EP_N; i++) begin
      is_in[i]    = (i == 32'(EP_CTL_IN)) ? 1'b1 :
                    (i == 32'(EP_CTL_OUT)) ? 1'b0 : ep_is_in_i[i];
      usb_side[i] = ep_dbl_i[i] & ~ep_reg[i].cpusel;
    end
  end

  function automatic logic [7:0] pack_st(input ues_ep_s s);
    logic [7:0] b;
    b = 8'h00;
    b[BIT_HALT]  = s.halted;
    b[BIT_FULL1] = s.full[1];
    b[BIT_FULL0] = s.full[0];
    b[BIT_TOG]   = s.toggle;
    b[BIT_CLOB]  = s.clobber;
    b[BIT_SETUP] = s.setup;
    b[BIT_CPU]   = s.cpusel;
    return b;
  endfunction

  function automatic ues_ep_s reinit(input ues_ep_s s);
    ues_ep_s r;
    r        = s;
    r.halted = 1'b0;
    r.full   = 2'b00;
    r.toggle = 1'b0;
    r.cpusel = 1'b0;
    return r;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic ctl_blk;
    logic sel;
    ctl_blk    = 1'b0;
    sel        = 1'b0;
    for (int i = 0; i < EP_N; i++) ep_next[i] = ep_reg[i];
    copy_next  = copy_reg;
    rdv_next   = 1'b0;
    irq_next   = 1'b0;
    irqe_next  = irqe_reg;
    prst_next  = 1'b0;
    prste_next = prste_reg;
    lock_next  = lock_reg;
    unst_next  = unst_reg;
    unste_next = unste_reg;
    ctl_blk    = lock_reg && (idx == EP_CTL_OUT || idx == EP_CTL_IN);

    // Commands first, so engine events below win a same-cycle clash
    if (cmd_i.valid) begin
      unst_next = 1'b0;
      sel       = ep_reg[idx].cpusel;
      if (cmd_i.code == CMD_ACK_SETUP) begin
        lock_next = 1'b0;
      end else begin
        case (op)
          OP_STALL: begin
            ep_next[idx].halted = 1'b1;
          end
          OP_UNSTALL: begin
            if (unst_reg && unste_reg == idx) begin
              prst_next  = 1'b1;
              prste_next = idx;
            end else begin
              unst_next  = 1'b1;
              unste_next = idx;
              if (ep_reg[idx].halted) begin
                ep_next[idx] = reinit(ep_reg[idx]);
              end
              ep_next[idx].halted = 1'b0;
            end
          end
          OP_VALIDATE: begin
            if (idx != EP_CTL_OUT && is_in[idx] && !ctl_blk) begin
              ep_next[idx].full[sel] = 1'b1;
              if (ep_dbl_i[idx]) ep_next[idx].cpusel = ~sel;
            end
          end
          OP_CLEAR: begin
            if (idx != EP_CTL_IN && !is_in[idx] && !ctl_blk) begin
              ep_next[idx].full[sel] = 1'b0;
              ep_next[idx].setup     = 1'b0;
              if (ep_dbl_i[idx]) ep_next[idx].cpusel = ~sel;
            end
          end
          OP_RDSTAT: begin
            copy_next = pack_st(ep_reg[idx]);
            rdv_next  = 1'b1;
            irq_next  = 1'b1;
            irqe_next = idx;
            if (!setup_busy_i) ep_next[idx].clobber = 1'b0;
          end
          OP_CHECK: begin
            copy_next = pack_st(ep_reg[idx]);
            rdv_next  = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end

    // Engine events
    if (usb_i.setup_tok) begin
      for (int c = 0; c < 2; c++) begin
        if (ep_reg[c].halted) ep_next[c] = reinit(ep_reg[c]);
      end
      if (ep_reg[EP_CTL_OUT].setup && lock_reg) begin
        ep_next[EP_CTL_OUT].clobber = 1'b1;
      end
      lock_next = 1'b1;
    end
    if (usb_i.setup_done) begin
      ep_next[EP_CTL_OUT].setup   = 1'b1;
      ep_next[EP_CTL_OUT].full[0] = 1'b1;
    end
    if (usb_i.out_done && !ep_reg[usb_i.ep].full[usb_side[usb_i.ep]]) begin
      ep_next[usb_i.ep].full[usb_side[usb_i.ep]] = 1'b1;
      ep_next[usb_i.ep].toggle = ~ep_reg[usb_i.ep].toggle;
    end
    if (usb_i.in_done) begin
      ep_next[usb_i.ep].full[usb_side[usb_i.ep]] = 1'b0;
      ep_next[usb_i.ep].toggle = ~ep_reg[usb_i.ep].toggle;
    end
  end

  // Full engine-side buffer or a halted endpoint refuses the data packet
  assign nak_o = ep_reg[usb_i.ep].full[usb_side[usb_i.ep]] | ep_reg[usb_i.ep].halted;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < EP_N; i++) ep_reg[i] <= EP_RST;
      copy_reg  <= COPY_RST;
      rdv_reg   <= 1'b0;
      irq_reg   <= 1'b0;
      irqe_reg  <= 4'h0;
      prst_reg  <= 1'b0;
      prste_reg <= 4'h0;
      lock_reg  <= 1'b0;
      unst_reg  <= 1'b0;
      unste_reg <= 4'h0;
    end else begin
      for (int i = 0; i < EP_N; i++) ep_reg[i] <= ep_next[i];
      copy_reg  <= copy_next;
      rdv_reg   <= rdv_next;
      irq_reg   <= irq_next;
      irqe_reg  <= irqe_next;
      prst_reg  <= prst_next;
      prste_reg <= prste_next;
      lock_reg  <= lock_next;
      unst_reg  <= unst_next;
      unste_reg <= unste_next;
    end
  end

  assign rd_data_o    = copy_reg;
  assign rd_valid_o   = rdv_reg;
  assign irq_clr_o    = irq_reg;
  assign irq_clr_ep_o = irqe_reg;
  assign ptr_rst_o    = prst_reg;
  assign ptr_rst_ep_o = prste_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_stall;
    @(posedge clk_sys_i) disable iff (rst_i)
    cmd_i.valid && op == OP_STALL |=> ep_reg[$past(idx)].halted;
  endproperty
  a_stall: assert property (p_stall) else $error("stall did not halt");

  property p_setup_unstall;
    @(posedge clk_sys_i) disable iff (rst_i)
    usb_i.setup_tok && !(cmd_i.valid && op == OP_STALL)
      |=> !ep_reg[EP_CTL_OUT].halted && !ep_reg[EP_CTL_IN].halted;
  endproperty
  a_setup_unstall: assert property (p_setup_unstall) else $error("setup kept stall");

  property p_reinit;
    @(posedge clk_sys_i) disable iff (rst_i)
    cmd_i.valid && op == OP_UNSTALL && ep_reg[idx].halted && !usb_i.out_done
      && !usb_i.setup_done |=> ep_reg[$past(idx)].full == 2'b00 && !ep_reg[$past(idx)].toggle;
  endproperty
  a_reinit: assert property (p_reinit) else $error("unstall did not flush");

  property p_second_unstall;
    @(posedge clk_sys_i) disable iff (rst_i)
    (cmd_i.valid && op == OP_UNSTALL ##1 cmd_i.valid && op == OP_UNSTALL
      && idx == $past(idx))
    or (cmd_i.valid && op == OP_UNSTALL ##1 !cmd_i.valid ##1 cmd_i.valid
      && op == OP_UNSTALL && idx == $past(idx, 2))
      |=> ptr_rst_o && ptr_rst_ep_o == $past(idx);
  endproperty
  a_second_unstall: assert property (p_second_unstall) else $error("no pointer reset");

  property p_validate;
    @(posedge clk_sys_i) disable iff (rst_i)
    cmd_i.valid && op == OP_VALIDATE && idx != EP_CTL_OUT && is_in[idx] && !ctl_blk_w
      && !usb_i.in_done |=> ep_reg[$past(idx)].full[$past(ep_reg[idx].cpusel)];
  endproperty
  a_validate: assert property (p_validate) else $error("validate lost");

  property p_dbl_flip;
    @(posedge clk_sys_i) disable iff (rst_i)
    cmd_i.valid && (op == OP_VALIDATE || op == OP_CLEAR) && ep_dbl_i[idx] && !ctl_blk_w
      && (op == OP_VALIDATE ? (is_in[idx] && idx != EP_CTL_OUT)
                            : (!is_in[idx] && idx != EP_CTL_IN))
      |=> ep_reg[$past(idx)].cpusel != $past(ep_reg[idx].cpusel);
  endproperty
  a_dbl_flip: assert property (p_dbl_flip) else $error("buffer select stuck");

  property p_nak;
    @(posedge clk_sys_i) disable iff (rst_i)
    usb_i.out_done && ep_reg[usb_i.ep].full[usb_side[usb_i.ep]] && !usb_i.in_done
      && !usb_i.setup_tok && !(cmd_i.valid && op == OP_UNSTALL)
      |-> nak_o ##1 ep_reg[$past(usb_i.ep)].toggle == $past(ep_reg[usb_i.ep].toggle);
  endproperty
  a_nak: assert property (p_nak) else $error("full buffer not refused");

  property p_check_keep;
    @(posedge clk_sys_i) disable iff (rst_i)
    cmd_i.valid && op == OP_CHECK && !usb_i.setup_tok
      |=> rd_valid_o && !irq_clr_o && rd_data_o == pack_st($past(ep_reg[idx]))
        && ep_reg[$past(idx)].clobber == $past(ep_reg[idx].clobber);
  endproperty
  a_check_keep: assert property (p_check_keep) else $error("check altered state");

  property p_rdstat_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
    cmd_i.valid && op == OP_RDSTAT |=> irq_clr_o && irq_clr_ep_o == $past(idx);
  endproperty
  a_rdstat_irq: assert property (p_rdstat_irq) else $error("irq not cleared");

  property p_lock;
    @(posedge clk_sys_i) disable iff (rst_i)
    lock_reg && cmd_i.valid && op == OP_VALIDATE && idx == EP_CTL_IN && !usb_i.in_done
      |=> ep_reg[EP_CTL_IN].full == $past(ep_reg[EP_CTL_IN].full);
  endproperty
  a_lock: assert property (p_lock) else $error("locked validate acted");

endmodule

// ===== tb/ues_host_model.sv
// Far-side serial engine model: raises token and packet events.
// Assumes the bench calls its task from one process at a time.
module ues_host_model
  import ues_pkg::*;
(
  // Clock
  input  wire logic clk_sys_i,
  // Engine side of the block
  input  wire logic nak_i,
  output ues_usb_s  usb_o,
  output logic      setup_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    usb_o = '0;
    setup_busy_o = 1'b0;
  end

  // ----------------------------------------
  // One-cycle event; refusal sampled mid-cycle, before the taking edge
  // ----------------------------------------
  // Idle endpoint shows the inverse, so a stale index never matches
  task automatic event_pulse(input ues_usb_s ev, input logic busy, output logic nak);
    @(posedge clk_sys_i);
    #10 usb_o = ev;
    setup_busy_o = busy;
    @(negedge clk_sys_i);
    nak = nak_i;
    @(posedge clk_sys_i);
    #10 usb_o = '{ep: ~ev.ep, default: 1'b0};
  endtask
endmodule

// ===== tb/usb_endpoint_status_control_test.sv
// Self-checking bench for the endpoint status and command block.
// Assumes the engine model owns usb_i; the bench plays the firmware.
module usb_endpoint_status_control_test
  import ues_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic            clk_sys_i;
  logic            rst_i;
  ues_cmd_s        cmd_i;
  logic [7:0]      rd_data_o;
  logic            rd_valid_o;
  logic            irq_clr_o;
  logic [3:0]      irq_clr_ep_o;
  logic            ptr_rst_o;
  logic [3:0]      ptr_rst_ep_o;
  logic [EP_N-1:0] ep_is_in_i;
  logic [EP_N-1:0] ep_dbl_i;
  ues_usb_s        usb_i;
  logic            setup_busy_i;
  logic            nak_o;
  logic            nak;
  int              num_errors;
  int              tests_run;

  ues_core ues_core_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_i(cmd_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .irq_clr_o(irq_clr_o),
    .irq_clr_ep_o(irq_clr_ep_o), .ptr_rst_o(ptr_rst_o), .ptr_rst_ep_o(ptr_rst_ep_o),
    .ep_is_in_i(ep_is_in_i), .ep_dbl_i(ep_dbl_i), .usb_i(usb_i),
    .setup_busy_i(setup_busy_i), .nak_o(nak_o));

  ues_host_model ues_host_model_inst (.clk_sys_i(clk_sys_i), .nak_i(nak_o),
    .usb_o(usb_i), .setup_busy_o(setup_busy_i));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Pulses are registered, so they are seen just after the taking edge
  task automatic issue(input logic [7:0] code);
    @(posedge clk_sys_i);
    #10 cmd_i = '{valid: 1'b1, code: code};
    @(posedge clk_sys_i);
    #10 cmd_i.valid = 1'b0;
  endtask

  task automatic rd(input logic [7:0] code, input logic [7:0] mask, input logic [7:0] exp);
    issue(code);
    chk("rd_valid_o", 8'h01, {7'h0, rd_valid_o});
    chk("rd_data_o", exp, rd_data_o & mask);
    chk("irq_clr_o", {7'h0, code[7:4] == OP_RDSTAT}, {7'h0, irq_clr_o});
    if (code[7:4] == OP_RDSTAT)
      chk("irq_clr_ep_o", {4'h0, code[3:0]}, {4'h0, irq_clr_ep_o});
  endtask

  task automatic pkt(input logic [3:0] ep, input logic tok, input logic done,
                     input logic busy);
    ues_host_model_inst.event_pulse('{setup_tok: tok, setup_done: done,
      out_done: !(tok | done), in_done: 1'b0, ep: ep}, busy, nak);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_stall_all;
    for (int i = 0; i < EP_N; i++) begin
      rd(8'hd0 | 8'(i), 8'hff, 8'h00);
      issue(8'h40 | 8'(i));
      rd(8'hd0 | 8'(i), 8'hff, 8'h80);
      issue(8'h80 | 8'(i));
      chk("ptr_rst_o", 8'h00, {7'h0, ptr_rst_o});
      issue(8'h80 | 8'(i));
      chk("ptr_rst_o", 8'h01, {7'h0, ptr_rst_o});
      chk("ptr_rst_ep_o", 8'(i), {4'h0, ptr_rst_ep_o});
      rd(8'h50 | 8'(i), 8'hff, 8'h00);
    end
  endtask

  task automatic t_out_ep;
    pkt(4'h2, 1'b0, 1'b0, 1'b0);
    chk("nak_o", 8'h00, {7'h0, nak});
    rd(8'hd2, 8'hff, 8'h30);
    pkt(4'h2, 1'b0, 1'b0, 1'b0);
    chk("nak_o", 8'h01, {7'h0, nak});
    rd(8'hd2, 8'hff, 8'h30);
    issue(8'h62);
    rd(8'hd2, 8'hff, 8'h30);
    issue(8'h72);
    rd(8'hd2, 8'hff, 8'h10);
    issue(8'h42);
    issue(8'h82);
    rd(8'hd2, 8'hff, 8'h00);
  endtask

  // Engine drains the non-CPU buffer of the double-buffered IN endpoint
  task automatic t_in_dbl;
    issue(8'h63);
    rd(8'hd3, 8'hff, 8'h22);
    issue(8'h63);
    rd(8'hd3, 8'hff, 8'h60);
    ues_host_model_inst.event_pulse('{setup_tok: 1'b0, setup_done: 1'b0, out_done: 1'b0,
      in_done: 1'b1, ep: 4'h3}, 1'b0, nak);
    rd(8'hd3, 8'hff, 8'h30);
  endtask

  task automatic t_setup;
    issue(8'h40);
    issue(8'h41);
    pkt(4'h0, 1'b1, 1'b0, 1'b1);
    pkt(4'h0, 1'b0, 1'b1, 1'b0);
    rd(8'hd0, 8'h8c, 8'h04);
    rd(8'hd1, 8'h80, 8'h00);
    issue(8'h61);
    rd(8'hd1, 8'h20, 8'h00);
    pkt(4'h0, 1'b1, 1'b0, 1'b1);
    rd(8'h50, 8'h08, 8'h08);
    rd(8'h50, 8'h08, 8'h08);
    pkt(4'h0, 1'b0, 1'b1, 1'b0);
    rd(8'h50, 8'h08, 8'h08);
    rd(8'hd0, 8'h08, 8'h00);
    issue(CMD_ACK_SETUP);
    issue(8'h61);
    rd(8'hd1, 8'h20, 8'h20);
  endtask

  // ----------------------------------------
  // Clock, reset, sequence
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    rst_i = 1'b1;
    cmd_i = '0;
    ep_is_in_i = 16'h0008;
    ep_dbl_i = 16'h0008;
    num_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clk_sys_i);
    #10 rst_i = 1'b0;
    t_stall_all();
    t_out_ep();
    t_in_dbl();
    t_setup();
    give_verdict();
  end

  // Whole sequence needs well under 1000 cycles
  initial begin
    #500000;
    num_errors++;
    give_verdict();
  end
endmodule
